// ==== rtl/iad_core.sv ====
`timescale 1ns/1ps
module iad_core
  import iad_pkg::*;
#(
  parameter int XLEN = 64
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic insn_valid,
  input wire logic [iad_pkg::INSN_W-1:0] insn_word,
  output logic insn_ready,
  output logic [4:0] src_sel,
  output logic [4:0] tgt_sel,
  input wire logic [XLEN-1:0] src_val,
  input wire logic [XLEN-1:0] tgt_val,
  output logic wr_en_q,
  output logic [4:0] wr_addr_q,
  output logic [XLEN-1:0] wr_data_q,
  output logic exc_valid_q,
  output logic [3:0] exc_code_q,
  input wire logic bl_resolve,
  input wire logic bl_taken,
  output logic cancel_delay_slot_q,
  output logic [27:0] jump_low_q,
  output logic cop_valid_q,
  output logic [1:0] cop_unit_q,
  output logic [iad_pkg::COPF_HI:0] cop_func_q,
  output logic insn_other_q,
  input wire logic loads_idle,
  input wire logic stores_idle,
  input wire logic bus_reads_idle,
  input wire logic wb_writes_idle,
  input wire logic older_done,
  output logic gather_stop_q,
  output logic ucab_inval_q,
  output logic fetch_hold,
  output logic barrier_done_q
);
  import iad_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the result path sign-extends a word, so it needs room above it
  if (XLEN <= WORD_W) begin : g_bad_xlen
    $error("iad_core: XLEN must exceed the word width");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  iad_state_e state_q; // barrier sequencer
  iad_state_e state_d;
  logic cancel_q; // next instruction is a dead delay slot
  logic cancel_d;

  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  // every format is one word; fields are plain slices of it
  wire [5:0] primary_opcode = insn_word[OP_HI:OP_LO];
  wire [4:0] source_reg_field = insn_word[RS_HI:RS_LO];
  wire [4:0] target_reg_field = insn_word[RT_HI:RT_LO];
  wire [15:0] imm_field = insn_word[IMM_HI:0];
  wire [4:0] dest_reg_field = insn_word[RD_HI:RD_LO];
  wire [4:0] shift_amount_field = insn_word[SA_HI:SA_LO];
  wire [5:0] func_field = insn_word[FN_HI:FN_LO];
  wire [25:0] jump_index = insn_word[IDX_HI:0];
  wire [COPF_HI:0] cop_field = insn_word[COPF_HI:0];
  // low bits of the jump target: index counted in words
  wire [27:0] jump_low = {jump_index, 2'b00};

  // register file read selects follow the word directly
  assign src_sel = source_reg_field;
  assign tgt_sel = target_reg_field;

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  wire is_reg_group = (primary_opcode == OP_REG_GROUP);
  // register-group members are picked by the function field
  wire is_add_reg_trap = is_reg_group &&
    (func_field == FN_ADD_REG_TRAP) &&
    (shift_amount_field == SA_ZERO);
  wire is_add_reg_wrap = is_reg_group &&
    (func_field == FN_ADD_REG_WRAP) &&
    (shift_amount_field == SA_ZERO);
  wire is_barrier = is_reg_group &&
    (func_field == FN_BARRIER);
  wire is_add_imm_trap = (primary_opcode == OP_ADD_IMM_TRAP);
  wire is_add_imm_wrap = (primary_opcode == OP_ADD_IMM_WRAP);
  // coprocessor operate form: 0100zz with bit 25 set
  wire is_cop = (primary_opcode[5:2] == OP_COP_PREFIX) &&
    insn_word[RS_HI];
  wire is_imm_add = is_add_imm_trap || is_add_imm_wrap;
  wire is_reg_add = is_add_reg_trap || is_add_reg_wrap;
  wire is_trap_add = is_add_imm_trap || is_add_reg_trap;
  wire is_known = is_imm_add || is_reg_add || is_barrier || is_cop;
  // barrier type sits in the shift amount position
  wire barrier_pipe = (shift_amount_field == BARRIER_PIPE_TYPE);

  // ----------------------------------------------------------------
  // word adder
  // ----------------------------------------------------------------
  wire [XLEN-1:0] imm_sext = {{(XLEN-16){imm_field[15]}}, imm_field};
  // second addend: register or sign-extended immediate
  wire [XLEN-1:0] addend_b = is_imm_add ? imm_sext : tgt_val;
  logic [WORD_W-1:0] sum_word; // low word of the sum
  logic sum_ovf; // signed word overflow

  // only the low words matter; upper bits are trusted equal
  iad_wadd #(
    .WIDTH(WORD_W)
  ) u_wadd (
    .a_word(src_val[WORD_W-1:0]),
    .b_word(addend_b[WORD_W-1:0]),
    .sum_word(sum_word),
    .ovf(sum_ovf)
  );

  // sign-extended result, the same for trap and wrap forms
  wire [XLEN-1:0] sum_sext =
    {{(XLEN-WORD_W){sum_word[WORD_W-1]}}, sum_word};
  // overflow only counts for the trapping pair
  wire trap_hit = is_trap_add && sum_ovf;
  // imm forms write the target field, reg forms the destination
  wire [4:0] result_reg = is_imm_add ? target_reg_field :
    dest_reg_field;

  // ----------------------------------------------------------------
  // acceptance
  // ----------------------------------------------------------------
  // barrier states stall the fetch side through the handshake
  assign insn_ready = (state_q == ST_IDLE);
  wire take = insn_valid && insn_ready;
  // a cancelled slot is consumed but does nothing
  wire live = take && !cancel_q;
  wire do_write = live && (is_reg_add || is_imm_add) &&
    !trap_hit;
  wire do_exc = live && trap_hit;
  wire do_cop = live && is_cop;
  wire do_barrier = live && is_barrier;
  wire do_other = live && !is_known;
  // every memory-side drain condition together
  wire mem_drained = loads_idle && stores_idle &&
    bus_reads_idle && wb_writes_idle;

  // ----------------------------------------------------------------
  // barrier sequencer
  // ----------------------------------------------------------------
  // next state; no new instruction enters while draining
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (do_barrier) begin
          // memory or pipeline flavour chosen by the type field
          state_d = barrier_pipe ? ST_PIPEB : ST_MEMB;
        end
      end
      ST_MEMB: begin
        // loads written back, stores out, bus quiet
        if (mem_drained) begin
          state_d = ST_IDLE;
        end
      end
      ST_PIPEB: begin
        // older_done excludes multiply, divide and the like
        if (older_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // younger fetch held while a pipeline barrier drains
  assign fetch_hold = (state_q == ST_PIPEB);

  // ----------------------------------------------------------------
  // delay-slot cancel flag
  // ----------------------------------------------------------------
  // a fresh untaken resolve beats the consume of the old one
  always_comb begin
    cancel_d = cancel_q;
    if (take) begin
      cancel_d = 1'b0;
    end
    if (bl_resolve && !bl_taken) begin
      cancel_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequential state
  // ----------------------------------------------------------------
  // state and cancel flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cancel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cancel_q <= cancel_d;
    end
  end

  // register write port; aborted adds leave it idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_en_q <= 1'b0;
      wr_addr_q <= 5'h00;
      wr_data_q <= '0;
    end else begin
      wr_en_q <= do_write;
      if (do_write) begin
        wr_addr_q <= result_reg;
        wr_data_q <= sum_sext;
      end
    end
  end

  // exception pulse toward the exception unit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exc_valid_q <= 1'b0;
      exc_code_q <= EXC_NONE;
    end else begin
      exc_valid_q <= do_exc;
      exc_code_q <= do_exc ? EXC_INT_OVERFLOW : EXC_NONE;
    end
  end

  // coprocessor dispatch and decoded jump bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cop_valid_q <= 1'b0;
      cop_unit_q <= 2'h0;
      cop_func_q <= '0;
      jump_low_q <= 28'h0000000;
    end else begin
      cop_valid_q <= do_cop;
      if (do_cop) begin
        cop_unit_q <= primary_opcode[1:0];
        cop_func_q <= cop_field;
      end
      if (take) begin
        jump_low_q <= jump_low;
      end
    end
  end

  // one-cycle event outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cancel_delay_slot_q <= 1'b0;
      insn_other_q <= 1'b0;
      gather_stop_q <= 1'b0;
      ucab_inval_q <= 1'b0;
      barrier_done_q <= 1'b0;
    end else begin
      cancel_delay_slot_q <= take && cancel_q;
      insn_other_q <= do_other;
      // gathering stopped and buffer dropped at memory barrier start; a pipeline barrier leaves both low
      gather_stop_q <= do_barrier && !barrier_pipe;
      ucab_inval_q <= do_barrier && !barrier_pipe;
      barrier_done_q <= (state_q != ST_IDLE) &&
        (state_d == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_trap_add_result: assert property (
    live && is_add_reg_trap && !sum_ovf |=>
      wr_en_q && wr_data_q == $past(sum_sext))
    else $error("trapping add result wrong");

  a_overflow_no_write: assert property (
    live && is_trap_add && sum_ovf |=>
      exc_valid_q && !wr_en_q && exc_code_q == EXC_INT_OVERFLOW)
    else $error("overflow did not trap");

  a_wrap_never_traps: assert property (
    live && is_add_imm_wrap |=> !exc_valid_q && wr_en_q)
    else $error("wrapping add trapped");

  a_exc_aborts: assert property (
    exc_valid_q |-> !wr_en_q && !cop_valid_q)
    else $error("exception did not abort");

  a_slot_cancelled: assert property (
    take && cancel_q |=> cancel_delay_slot_q && !wr_en_q &&
      !exc_valid_q && !cop_valid_q)
    else $error("delay slot not cancelled");

  a_barrier_select: assert property (
    do_barrier && barrier_pipe |=> state_q == ST_PIPEB ##0
      !gather_stop_q)
    else $error("barrier type misread");

  a_mem_drain_hold: assert property (
    state_q == ST_MEMB && !mem_drained |=>
      state_q == ST_MEMB && !insn_ready)
    else $error("memory barrier left early");

  a_mem_gather_stop: assert property (
    do_barrier && !barrier_pipe |=>
      gather_stop_q && ucab_inval_q ##1 !gather_stop_q)
    else $error("gathering not stopped");

  a_pipe_fetch_hold: assert property (
    state_q == ST_PIPEB && !older_done |=>
      fetch_hold && !insn_ready)
    else $error("pipeline barrier released early");

  a_pipe_release: assert property (
    state_q == ST_PIPEB && older_done |=>
      insn_ready && barrier_done_q)
    else $error("pipeline barrier stuck");

  a_cop_function: assert property (
    do_cop |=> cop_valid_q && cop_func_q == $past(cop_field))
    else $error("coprocessor function lost");

  a_jump_index: assert property (
    take |=> jump_low_q == {$past(jump_index), 2'b00})
    else $error("jump bits wrong");

  c_overflow_trap: cover property (do_exc ##1 exc_valid_q);
  c_mem_barrier: cover property (
    state_q == ST_MEMB ##1 barrier_done_q);
  c_pipe_barrier: cover property (
    state_q == ST_PIPEB ##1 barrier_done_q);
  c_slot_cancel: cover property (
    bl_resolve && !bl_taken ##[1:4] cancel_delay_slot_q);
endmodule : iad_core

// ==== rtl/iad_pkg.sv ====
package iad_pkg;
  // ----------------------------------------------------------------
  // instruction word layout
  // ----------------------------------------------------------------
  localparam int INSN_W = 32;        // one aligned instruction word
  localparam int OP_HI = 31;         // primary opcode
  localparam int OP_LO = 26;
  localparam int RS_HI = 25;         // source register field
  localparam int RS_LO = 21;
  localparam int RT_HI = 20;         // target register field
  localparam int RT_LO = 16;
  localparam int RD_HI = 15;         // destination specifier
  localparam int RD_LO = 11;
  localparam int SA_HI = 10;         // shift amount field
  localparam int SA_LO = 6;
  localparam int FN_HI = 5;          // function code
  localparam int FN_LO = 0;
  localparam int IMM_HI = 15;        // immediate field
  localparam int IDX_HI = 25;        // jump index field
  localparam int IDX_SHIFT = 2;      // index is a word count
  localparam int COPF_HI = 24;       // coprocessor function field
  localparam int WORD_W = 32;        // word-add width

  // ----------------------------------------------------------------
  // opcode and function encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_REG_GROUP = 6'h00;
  localparam logic [5:0] OP_ADD_IMM_TRAP = 6'h08;
  localparam logic [5:0] OP_ADD_IMM_WRAP = 6'h09;
  localparam logic [3:0] OP_COP_PREFIX = 4'h4;   // 0100zz
  localparam logic [5:0] FN_ADD_REG_TRAP = 6'h20;
  localparam logic [5:0] FN_ADD_REG_WRAP = 6'h21;
  localparam logic [5:0] FN_BARRIER = 6'h0F;
  localparam logic [4:0] SA_ZERO = 5'h00;
  localparam logic [4:0] BARRIER_PIPE_TYPE = 5'h10;

  // ----------------------------------------------------------------
  // exception codes and barrier states
  // ----------------------------------------------------------------
  localparam logic [3:0] EXC_NONE = 4'h0;
  localparam logic [3:0] EXC_INT_OVERFLOW = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,     // accepting instructions
    ST_MEMB = 2'h1,     // memory barrier draining
    ST_PIPEB = 2'h2     // pipeline barrier draining
  } iad_state_e;
endpackage : iad_pkg

// ==== rtl/iad_wadd.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// signed word adder with overflow flag
// ------------------------------------------------------------------
module iad_wadd #(
  parameter int WIDTH = 32
) (
  input wire logic [WIDTH-1:0] a_word,
  input wire logic [WIDTH-1:0] b_word,
  output logic [WIDTH-1:0] sum_word,
  output logic ovf
);
  // modulo sum, carry out dropped on purpose
  assign sum_word = a_word + b_word;
  // same-sign addends, result sign flipped
  assign ovf = (a_word[WIDTH-1] == b_word[WIDTH-1]) &&
               (sum_word[WIDTH-1] != a_word[WIDTH-1]);
endmodule : iad_wadd

// ==== test/iad_partner.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// far side: register file, memory system drain and older work
// ------------------------------------------------------------------
module iad_partner (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] src_sel,
  input wire logic [4:0] tgt_sel,
  output logic [63:0] src_val,
  output logic [63:0] tgt_val,
  input wire logic wr_en_q,
  input wire logic [4:0] wr_addr_q,
  input wire logic [63:0] wr_data_q,
  input wire logic busy_set,
  input wire logic [3:0] busy_len,
  input wire logic [2:0] busy_sel,
  output logic loads_idle,
  output logic stores_idle,
  output logic bus_reads_idle,
  output logic wb_writes_idle,
  output logic older_done
);
  logic [63:0] regs [0:31]; // preset by the bench, not reset
  logic [3:0] busy_q;       // cycles of pending work left
  logic [2:0] sel_q;        // which drain signal stays low
  logic [4:0] idle_w;       // one bit per drain signal

  // combinational read, same cycle as the select
  assign src_val = regs[src_sel];
  assign tgt_val = regs[tgt_sel];

  // only one signal lags, so a design that ignores it ends too early
  assign idle_w = (busy_q != 4'h0) ? ~(5'h01 << sel_q) : 5'h1F;
  assign loads_idle = idle_w[0];
  assign stores_idle = idle_w[1];
  assign bus_reads_idle = idle_w[2];
  assign wb_writes_idle = idle_w[3];
  assign older_done = idle_w[4];

  // ----------------------------------------------------------------
  // write port and pending-work counter
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (wr_en_q) begin
      regs[wr_addr_q] <= wr_data_q;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_q <= 4'h0;
      sel_q <= 3'h0;
    end else if (busy_set) begin
      busy_q <= busy_len;
      sel_q <= busy_sel;
    end else if (busy_q != 4'h0) begin
      busy_q <= busy_q - 4'h1;
    end
  end
endmodule : iad_partner

// ==== test/insn_format_add_barrier_test.sv ====
`timescale 1ns/1ps
module insn_format_add_barrier_test;
  import iad_pkg::*;
  // ----------------------------------------------------------------
  // stimulus, observed outputs, bookkeeping
  // ----------------------------------------------------------------
  typedef logic [76:0] iad_ev_t; // {event mask, register, data}
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic insn_valid = 1'b0;
  logic [31:0] insn_word = 32'h0;
  logic bl_resolve = 1'b0;
  logic bl_taken = 1'b0;
  logic busy_set = 1'b0;
  logic [3:0] busy_len = 4'h0;
  logic [2:0] busy_sel = 3'h0;
  logic [4:0] src_sel, tgt_sel, wr_addr_q;
  logic [63:0] src_val, tgt_val, wr_data_q;
  logic insn_ready, wr_en_q, exc_valid_q, cancel_delay_slot_q;
  logic cop_valid_q, insn_other_q, gather_stop_q, ucab_inval_q;
  logic fetch_hold, barrier_done_q;
  logic loads_idle, stores_idle, bus_reads_idle, wb_writes_idle;
  logic older_done;
  logic [3:0] exc_code_q;
  logic [27:0] jump_low_q;
  logic [1:0] cop_unit_q;
  logic [24:0] cop_func_q;
  iad_ev_t exp_q [$]; // expected events, oldest first
  iad_ev_t seen;
  logic [7:0] seen_m;
  integer seed = 32'h0d3c0246;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] w;
  logic [25:0] idx;

  always #50 mclk = ~mclk;

  iad_core i_dut (.mclk(mclk), .rst(rst), .insn_valid(insn_valid),
    .insn_word(insn_word), .insn_ready(insn_ready), .src_sel(src_sel),
    .tgt_sel(tgt_sel), .src_val(src_val), .tgt_val(tgt_val),
    .wr_en_q(wr_en_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q),
    .exc_valid_q(exc_valid_q), .exc_code_q(exc_code_q),
    .bl_resolve(bl_resolve), .bl_taken(bl_taken),
    .cancel_delay_slot_q(cancel_delay_slot_q), .jump_low_q(jump_low_q),
    .cop_valid_q(cop_valid_q), .cop_unit_q(cop_unit_q),
    .cop_func_q(cop_func_q), .insn_other_q(insn_other_q),
    .loads_idle(loads_idle), .stores_idle(stores_idle),
    .bus_reads_idle(bus_reads_idle), .wb_writes_idle(wb_writes_idle),
    .older_done(older_done), .gather_stop_q(gather_stop_q),
    .ucab_inval_q(ucab_inval_q), .fetch_hold(fetch_hold),
    .barrier_done_q(barrier_done_q));

  iad_partner i_part (.mclk(mclk), .rst(rst), .src_sel(src_sel),
    .tgt_sel(tgt_sel), .src_val(src_val), .tgt_val(tgt_val),
    .wr_en_q(wr_en_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q),
    .busy_set(busy_set), .busy_len(busy_len), .busy_sel(busy_sel),
    .loads_idle(loads_idle), .stores_idle(stores_idle),
    .bus_reads_idle(bus_reads_idle), .wb_writes_idle(wb_writes_idle),
    .older_done(older_done));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic iad_ev_t ev(input logic [7:0] m, input logic [4:0] a,
                                 input logic [63:0] d);
    return {m, a, d};
  endfunction : ev

  task automatic check(input iad_ev_t s, input iad_ev_t e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic give_verdict;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // offers a word; returns at the falling edge before it is taken
  task automatic offer(input logic [31:0] word);
    int n = 0;
    insn_valid <= 1'b1;
    insn_word <= word;
    @(negedge mclk);
    while (insn_ready !== 1'b1 && n < 60) begin
      n++;
      @(negedge mclk);
    end
  endtask : offer

  // called just after a rising edge; returns at the taking edge
  task automatic issue(input logic [31:0] word);
    offer(word);
    @(posedge mclk);
  endtask : issue

  task automatic idle_cyc;
    insn_valid <= 1'b0;
    @(posedge mclk);
  endtask : idle_cyc

  // k: 0 trap reg, 1 wrap reg, 2 trap imm, 3 wrap imm
  task automatic do_add(input int k, input logic [4:0] s, input logic [4:0] t,
                        input logic [4:0] d, input logic [15:0] imm,
                        input logic [4:0] sa);
    logic [63:0] a, b;
    logic [31:0] sum, word;
    logic ovf;
    if (k < 2) begin
      word = {OP_REG_GROUP, s, t, d, sa,
              (k == 1) ? FN_ADD_REG_WRAP : FN_ADD_REG_TRAP};
    end else begin
      word = {(k == 2) ? OP_ADD_IMM_TRAP : OP_ADD_IMM_WRAP, s, t, imm};
    end
    // operands read in the taking cycle, before the write of the add just before has landed
    offer(word);
    a = i_part.regs[s];
    b = (k < 2) ? i_part.regs[t] : {{48{imm[15]}}, imm};
    sum = a[31:0] + b[31:0];
    ovf = (a[31] == b[31]) && (sum[31] != a[31]) && (k % 2 == 0);
    if (k < 2 && sa != 5'h00) begin
      exp_q.push_back(ev(8'h10, 5'h00, 64'h0));
    end else if (ovf) begin
      exp_q.push_back(ev(8'h02, 5'h00, {60'h0, EXC_INT_OVERFLOW}));
    end else begin
      exp_q.push_back(ev(8'h01, (k < 2) ? d : t, {{32{sum[31]}}, sum}));
    end
    @(posedge mclk);
  endtask : do_add

  // ----------------------------------------------------------------
  // output watcher: each event takes the oldest note
  // ----------------------------------------------------------------
  // falling edge, so registered pulses are settled when looked at
  always @(negedge mclk) begin
    if (!rst) begin
      seen_m = {barrier_done_q, ucab_inval_q, gather_stop_q, insn_other_q,
                cancel_delay_slot_q, cop_valid_q, exc_valid_q, wr_en_q};
      if (seen_m !== 8'h00) begin
        if (wr_en_q) seen = ev(seen_m, wr_addr_q, wr_data_q);
        else if (exc_valid_q) seen = ev(seen_m, 5'h00, {60'h0, exc_code_q});
        else if (cop_valid_q) seen = ev(seen_m, 5'h00,
                                        {37'h0, cop_unit_q, cop_func_q});
        else seen = ev(seen_m, 5'h00, 64'h0);
        if (exp_q.size() == 0) check(seen, {77{1'bx}});
        else check(seen, exp_q.pop_front());
      end
    end
  end

  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      $display("run stopped after %0d cycles", cycles);
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 1; i < 32; i++) begin
      w = $random(seed);
      i_part.regs[i] = {{32{w[31]}}, w};
    end
    i_part.regs[1] = 64'h000000007FFFFFFF;
    i_part.regs[2] = 64'hFFFFFFFF80000000;
    i_part.regs[3] = 64'hFFFFFFFFFFFFFFFF;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // back-to-back adds; sources 1..15 are never written
    for (int i = 0; i < 24; i++) begin
      do_add($unsigned($random(seed)) % 4,
             5'h01 + $unsigned($random(seed)) % 15,
             5'h10 + $unsigned($random(seed)) % 16,
             5'h10 + $unsigned($random(seed)) % 16, $random(seed), 5'h00);
    end
    idle_cyc();
    $display("test random_adds finished");
    do_add(0, 5'h01, 5'h01, 5'h10, 16'h0, 5'h00);
    do_add(0, 5'h02, 5'h03, 5'h11, 16'h0, 5'h00);
    do_add(0, 5'h01, 5'h03, 5'h12, 16'h0, 5'h00);
    do_add(2, 5'h01, 5'h13, 5'h00, 16'h0001, 5'h00);
    do_add(3, 5'h01, 5'h14, 5'h00, 16'h0001, 5'h00);
    do_add(2, 5'h02, 5'h15, 5'h00, 16'hFFFF, 5'h00);
    do_add(0, 5'h04, 5'h05, 5'h16, 16'h0, 5'h01);
    do_add(1, 5'h04, 5'h05, 5'h16, 16'h0, 5'h1F);
    idle_cyc();
    $display("test overflow_edges finished");
    idx = $random(seed);
    exp_q.push_back(ev(8'h10, 5'h00, 64'h0));
    issue({6'h02, idx});
    idle_cyc();
    @(negedge mclk);
    check({49'h0, jump_low_q}, {49'h0, idx, 2'b00});
    @(posedge mclk);
    for (int z = 0; z < 4; z++) begin
      w = $random(seed);
      exp_q.push_back(ev(8'h04, 5'h00, {37'h0, z[1:0], w[24:0]}));
      issue({OP_COP_PREFIX, z[1:0], 1'b1, w[24:0]});
    end
    idle_cyc();
    $display("test jump_and_coprocessor finished");
    for (int tk = 0; tk < 2; tk++) begin
      bl_resolve <= 1'b1;
      bl_taken <= tk[0];
      @(posedge mclk);
      bl_resolve <= 1'b0;
      if (tk == 0) begin
        exp_q.push_back(ev(8'h08, 5'h00, 64'h0));
        issue({OP_REG_GROUP, 5'h01, 5'h01, 5'h17, SA_ZERO, FN_ADD_REG_TRAP});
      end else begin
        do_add(1, 5'h06, 5'h07, 5'h17, 16'h0, 5'h00);
      end
      idle_cyc();
    end
    $display("test delay_slot finished");
    // selects 0..3 memory barrier with one lagging drain, 4 pipeline
    for (int sel = 0; sel < 5; sel++) begin
      busy_set <= 1'b1;
      busy_len <= 4'h6;
      busy_sel <= sel[2:0];
      @(posedge mclk);
      busy_set <= 1'b0;
      if (sel < 4) exp_q.push_back(ev(8'h60, 5'h00, 64'h0));
      exp_q.push_back(ev(8'h80, 5'h00, 64'h0));
      issue({OP_REG_GROUP, 15'h0000,
             (sel == 4) ? BARRIER_PIPE_TYPE : {3'h0, sel[1:0]}, FN_BARRIER});
      insn_valid <= 1'b0;
      repeat (3) begin
        @(negedge mclk);
        check({76'h0, insn_ready}, 77'h0);
        check({76'h0, fetch_hold}, {76'h0, sel == 4});
      end
      @(posedge mclk);
      do_add(3, 5'h08, 5'h18, 5'h00, 16'h7FFF, 5'h00);
      idle_cyc();
    end
    $display("test barriers finished");
    repeat (20) @(posedge mclk);
    check({45'h0, 32'(exp_q.size())}, 77'h0);
    give_verdict;
  end
endmodule : insn_format_add_barrier_test
